/* hw/sfpc_map.vh */
`ifndef SFPC_MAP_VH
`define SFPC_MAP_VH

// Register byte offsets
`define SFPC_ADDR_MODE 8'h00
`define SFPC_ADDR_TXD  8'h04
`define SFPC_ADDR_RXD  8'h08
`define SFPC_ADDR_FCR  8'h0c
`define SFPC_ADDR_FDR  8'h10
`define SFPC_ADDR_SPTR 8'h14
`define SFPC_ADDR_LSR  8'h18
`define SFPC_ADDR_STAT 8'h1c

// Mode register fields
`define SFPC_MODE_SYNC  0
`define SFPC_MODE_CHR7  1
`define SFPC_MODE_PEN   2
`define SFPC_MODE_ODD   3
`define SFPC_MODE_STOP2 4
`define SFPC_MODE_CKS   5
`define SFPC_MODE_TXEN  7
`define SFPC_MODE_RXEN  8
`define SFPC_MODE_DIV   16
`define SFPC_MODE_MASK  24'hff01ff
`define SFPC_MODE_RST   24'h000000

// FIFO control fields
`define SFPC_FCR_LOOP  0
`define SFPC_FCR_RCLR  1
`define SFPC_FCR_TCLR  2
`define SFPC_FCR_MCE   3
`define SFPC_FCR_RTSLV 8
`define SFPC_FCR_MASK  11'h7ff
`define SFPC_FCR_RST   11'h000

// Fill count and pin port
`define SFPC_FDR_TX    8
`define SFPC_SPTR_RST  8'h50

// Oversampling timing
`define SFPC_OVS_LAST  4'hf
`define SFPC_SMP_PH    4'h7

// Bus answers
`define SFPC_RESP_OK   2'b00
`define SFPC_RESP_ERR  2'b10
`endif

/* hw/sfpc_top.v */
`timescale 1ns/1ps
`include "sfpc_map.vh"
module sfpc_top #(
    parameter FIFO_AW = 4
) (
    input  wire        ref_clk_in,
    input  wire        reset_n_in,
    input  wire [7:0]  s_axi_awaddr_in,
    input  wire        s_axi_awvalid_in,
    output wire        s_axi_awready_out,
    input  wire [31:0] s_axi_wdata_in,
    input  wire [3:0]  s_axi_wstrb_in,
    input  wire        s_axi_wvalid_in,
    output wire        s_axi_wready_out,
    output wire [1:0]  s_axi_bresp_out,
    output wire        s_axi_bvalid_out,
    input  wire        s_axi_bready_in,
    input  wire [7:0]  s_axi_araddr_in,
    input  wire        s_axi_arvalid_in,
    output wire        s_axi_arready_out,
    output wire [31:0] s_axi_rdata_out,
    output wire [1:0]  s_axi_rresp_out,
    output wire        s_axi_rvalid_out,
    input  wire        s_axi_rready_in,
    input  wire        rxd_in,
    output wire        txd_out,
    input  wire        sck_in,
    output wire        sck_out,
    output wire        sck_oe_out,
    input  wire        rts_in,
    output wire        rts_out,
    output wire        rts_oe_out,
    input  wire        cts_in,
    output wire        cts_out,
    output wire        cts_oe_out
);

localparam [FIFO_AW:0] FULL = {1'b1, {FIFO_AW{1'b0}}};
localparam             DEP  = 1 << FIFO_AW;

// Reset release through two flops
reg rst1_r;
reg rst_r;
always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        rst1_r <= 1'b0;
        rst_r  <= 1'b0;
    end else begin
        rst1_r <= 1'b1;
        rst_r  <= rst1_r;
    end
end

// Pin synchronisers {rts, cts, sck, rxd}; first stage feeds only the second
reg [3:0] s1_r;
reg [3:0] s2_r;
reg       sckd_r;
always @(posedge ref_clk_in or negedge rst_r) begin
    if (!rst_r) begin
        s1_r   <= 4'h0;
        s2_r   <= 4'h0;
        sckd_r <= 1'b0;
    end else begin
        s1_r   <= {rts_in, cts_in, sck_in, rxd_in};
        s2_r   <= s1_r;
        sckd_r <= s2_r[1];
    end
end

// Software state
reg [23:0]        mode_r;
reg [10:0]        fcr_r;
reg [7:0]         sptr_r;
reg               rx_overrun_flag_r;
reg               rx_overrun_flag_seen_r;
reg               fer_r;
reg               per_r;
reg               brk_r;
reg [7:0]         tmem [0:DEP-1];
reg [7:0]         rmem [0:DEP-1];
reg [FIFO_AW-1:0] twp_r;
reg [FIFO_AW-1:0] trp_r;
reg [FIFO_AW:0]   tcnt_r;
reg [FIFO_AW-1:0] rwp_r;
reg [FIFO_AW-1:0] rrp_r;
reg [FIFO_AW:0]   rcnt_r;

wire       sync  = mode_r[`SFPC_MODE_SYNC];
wire       chr7  = mode_r[`SFPC_MODE_CHR7] & ~sync;
wire       pen   = mode_r[`SFPC_MODE_PEN] & ~sync;
wire       podd  = mode_r[`SFPC_MODE_ODD];
wire       stop2 = mode_r[`SFPC_MODE_STOP2];
wire [1:0] cks   = mode_r[`SFPC_MODE_CKS+1:`SFPC_MODE_CKS];
wire       txen  = mode_r[`SFPC_MODE_TXEN];
wire       rxen  = mode_r[`SFPC_MODE_RXEN];
wire [7:0] div   = mode_r[`SFPC_MODE_DIV+7:`SFPC_MODE_DIV];
wire       loop  = fcr_r[`SFPC_FCR_LOOP];
wire       rclr  = fcr_r[`SFPC_FCR_RCLR];
wire       tclr  = fcr_r[`SFPC_FCR_TCLR];
wire       modem_ctrl_enable   = fcr_r[`SFPC_FCR_MCE];

// Clock events: 10 selects the pin clock, 11 is treated as internal
wire ext      = (cks == 2'b10);
wire sck_rise = s2_r[1] & ~sckd_r;
wire sck_fall = ~s2_r[1] & sckd_r;
reg [7:0] dcnt_r;
reg [3:0] sph_r;
wire div_tick = (dcnt_r == div);
wire t16      = ext ? sck_rise : div_tick;
wire sh_ev    = ext ? sck_fall : (div_tick & (sph_r == `SFPC_OVS_LAST));
wire smp_ev   = ext ? sck_rise : (div_tick & (sph_r == `SFPC_SMP_PH));
always @(posedge ref_clk_in or negedge rst_r) begin
    if (!rst_r) begin
        dcnt_r <= 8'h00;
        sph_r  <= 4'h0;
    end else begin
        dcnt_r <= div_tick ? 8'h00 : dcnt_r + 8'h01;
        if (div_tick)
            sph_r <= sph_r + 4'h1;
    end
end

// Output pin flops
reg txd_r;
reg sck_r;
reg sck_oe_r;
reg rts_r;
reg rts_oe_r;
reg cts_r;
reg cts_oe_r;

// Clear-to-send seen by the transmitter; low means go
wire cts_lvl = ~modem_ctrl_enable ? 1'b0 : (loop ? rts_r : s2_r[2]);

// Transmitter: frame is shifted out LSB first, idle ones fill behind
reg        tbusy_r;
reg [11:0] tsr_r;
reg [3:0]  tleft_r;
reg [3:0]  tph_r;
wire [7:0] td    = tmem[trp_r];
wire       tpar  = ^(chr7 ? {1'b0, td[6:0]} : td) ^ podd;
wire [11:0] tfrm = sync ? {4'hf, td} :
                   chr7 ? {3'b111, pen ? tpar : 1'b1, td[6:0], 1'b0} :
                          {2'b11, pen ? tpar : 1'b1, td, 1'b0};
wire [3:0] tlen  = sync ? 4'h8 : 4'ha - {3'h0, chr7} + {3'h0, pen}
                   + {3'h0, stop2};
wire tgo  = ~tbusy_r & (tcnt_r != 0) & txen & ~tclr & ~cts_lvl
            & (sync ? sh_ev : t16);
wire tadv = sync ? sh_ev : (t16 & (tph_r == `SFPC_OVS_LAST));
always @(posedge ref_clk_in or negedge rst_r) begin
    if (!rst_r) begin
        tbusy_r <= 1'b0;
        tsr_r   <= 12'hfff;
        tleft_r <= 4'h0;
        tph_r   <= 4'h0;
    end else if (tgo) begin
        tbusy_r <= 1'b1;
        tsr_r   <= tfrm;
        tleft_r <= tlen;
        tph_r   <= 4'h0;
    end else if (tbusy_r) begin
        if (t16)
            tph_r <= tph_r + 4'h1;
        if (tadv) begin
            tsr_r   <= {1'b1, tsr_r[11:1]};
            tleft_r <= tleft_r - 4'h1;
            if (tleft_r == 4'h1)
                tbusy_r <= 1'b0;
        end
    end
end
wire tx_line = tbusy_r ? tsr_r[0] : 1'b1;

// Receiver: samples mid-bit on the eighth oversample pulse
reg        rbusy_r;
reg [11:0] rsr_r;
reg [3:0]  ridx_r;
reg [3:0]  rph_r;
reg        rdone_r;
wire       rx_line = loop ? txd_r : s2_r[0];
wire       rx_go   = rxen & ~rx_overrun_flag_r;
wire [3:0] rlen    = sync ? 4'h8 : 4'ha - {3'h0, chr7} + {3'h0, pen};
wire       samp    = sync ? smp_ev : (rbusy_r & t16 & (rph_r == `SFPC_SMP_PH));
always @(posedge ref_clk_in or negedge rst_r) begin
    if (!rst_r) begin
        rbusy_r <= 1'b0;
        rsr_r   <= 12'h000;
        ridx_r  <= 4'h0;
        rph_r   <= 4'h0;
        rdone_r <= 1'b0;
    end else begin
        rdone_r <= 1'b0;
        if (!rx_go) begin
            rbusy_r <= 1'b0;
            ridx_r  <= 4'h0;
        end else if (!sync && !rbusy_r) begin
            if (t16 && !rx_line) begin
                rbusy_r <= 1'b1;
                rph_r   <= 4'h0;
                ridx_r  <= 4'h0;
            end
        end else begin
            if (t16 && !sync)
                rph_r <= rph_r + 4'h1;
            if (samp) begin
                rsr_r[ridx_r] <= rx_line;
                if (!sync && ridx_r == 4'h0 && rx_line) begin
                    rbusy_r <= 1'b0;                 // Glitch, not a start bit
                end else if (ridx_r == rlen - 4'h1) begin
                    rbusy_r <= 1'b0;
                    ridx_r  <= 4'h0;
                    rdone_r <= 1'b1;
                end else begin
                    ridx_r <= ridx_r + 4'h1;
                end
            end
        end
    end
end

// Character check one cycle after the last sample
wire [7:0] rd_chr = sync ? rsr_r[7:0] :
                    chr7 ? {1'b0, rsr_r[7:1]} : rsr_r[8:1];
wire [3:0] pidx   = 4'h9 - {3'h0, chr7};
wire       pbit   = rsr_r[pidx];
wire       sbit   = rsr_r[pidx + {3'h0, pen}];
wire       c_fer  = rdone_r & ~sync & ~sbit;
wire       c_per  = rdone_r & pen & (^rd_chr ^ pbit ^ podd);
wire       c_brk  = c_fer & (rd_chr == 8'h00) & ~(pen & pbit);
wire       c_ovr  = rdone_r & (rcnt_r == FULL);
wire       rpush  = rdone_r & (rcnt_r != FULL) & ~rclr;

// Bus slave state
reg        awrdy_r;
reg        wrdy_r;
reg        bvalid_r;
reg [1:0]  bresp_r;
reg [7:0]  waddr_r;
reg [31:0] wdata_r;
reg [3:0]  wstrb_r;
reg        arrdy_r;
reg        rvalid_r;
reg [31:0] rdata_r;
reg [1:0]  rresp_r;
wire wr_go = ~awrdy_r & ~wrdy_r & ~bvalid_r;
wire rd_go = s_axi_arvalid_in & arrdy_r;
wire [31:0] wm = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
wire [31:0] wv = wdata_r & wm;
wire        w_mode = wr_go & (waddr_r == `SFPC_ADDR_MODE);
wire        w_txd  = wr_go & (waddr_r == `SFPC_ADDR_TXD);
wire        w_fcr  = wr_go & (waddr_r == `SFPC_ADDR_FCR);
wire        w_sptr = wr_go & (waddr_r == `SFPC_ADDR_SPTR);
wire        w_lsr  = wr_go & (waddr_r == `SFPC_ADDR_LSR);
wire        w_stat = wr_go & (waddr_r == `SFPC_ADDR_STAT);
wire        w_ok   = w_mode | w_txd | w_fcr | w_sptr | w_lsr | w_stat |
                     (wr_go & (waddr_r == `SFPC_ADDR_RXD)) |
                     (wr_go & (waddr_r == `SFPC_ADDR_FDR));

// FIFO traffic; a push to a full transmit FIFO is dropped
wire tpush = w_txd & wstrb_r[0] & (tcnt_r != FULL) & ~tclr;
wire rpop  = rd_go & (s_axi_araddr_in == `SFPC_ADDR_RXD) & (rcnt_r != 0) & ~rclr;

// FIFO pointers and fill counters
always @(posedge ref_clk_in or negedge rst_r) begin
    if (!rst_r) begin
        twp_r  <= {FIFO_AW{1'b0}};
        trp_r  <= {FIFO_AW{1'b0}};
        tcnt_r <= {(FIFO_AW+1){1'b0}};
        rwp_r  <= {FIFO_AW{1'b0}};
        rrp_r  <= {FIFO_AW{1'b0}};
        rcnt_r <= {(FIFO_AW+1){1'b0}};
    end else begin
        if (tclr) begin
            twp_r  <= {FIFO_AW{1'b0}};
            trp_r  <= {FIFO_AW{1'b0}};
            tcnt_r <= {(FIFO_AW+1){1'b0}};
        end else begin
            if (tpush)
                twp_r <= twp_r + 1'b1;
            if (tgo)
                trp_r <= trp_r + 1'b1;
            tcnt_r <= tcnt_r + {{FIFO_AW{1'b0}}, tpush}
                      - {{FIFO_AW{1'b0}}, tgo};
        end
        if (rclr) begin
            rwp_r  <= {FIFO_AW{1'b0}};
            rrp_r  <= {FIFO_AW{1'b0}};
            rcnt_r <= {(FIFO_AW+1){1'b0}};
        end else begin
            if (rpush)
                rwp_r <= rwp_r + 1'b1;
            if (rpop)
                rrp_r <= rrp_r + 1'b1;
            rcnt_r <= rcnt_r + {{FIFO_AW{1'b0}}, rpush}
                      - {{FIFO_AW{1'b0}}, rpop};
        end
    end
end

// FIFO storage has no reset; the counters say what is valid
always @(posedge ref_clk_in) begin
    if (tpush)
        tmem[twp_r] <= wdata_r[7:0];
    if (rpush)
        rmem[rwp_r] <= rd_chr;
end

// Software registers and flags; a hardware set beats a clear
always @(posedge ref_clk_in or negedge rst_r) begin
    if (!rst_r) begin
        mode_r      <= `SFPC_MODE_RST;
        fcr_r       <= `SFPC_FCR_RST;
        sptr_r      <= `SFPC_SPTR_RST;
        rx_overrun_flag_r      <= 1'b0;
        rx_overrun_flag_seen_r <= 1'b0;
        fer_r       <= 1'b0;
        per_r       <= 1'b0;
        brk_r       <= 1'b0;
    end else begin
        if (w_mode)
            mode_r <= ((mode_r & ~wm[23:0]) | wv[23:0]) & `SFPC_MODE_MASK;
        if (w_fcr)
            fcr_r <= ((fcr_r & ~wm[10:0]) | wv[10:0]) & `SFPC_FCR_MASK;
        if (w_sptr)
            sptr_r <= (sptr_r & ~wm[7:0]) | wv[7:0];
        // Clear only by a zero write that follows a read of one
        if (c_ovr) begin
            rx_overrun_flag_r <= 1'b1;
        end else if (w_lsr && wstrb_r[0] && !wdata_r[0] && rx_overrun_flag_seen_r) begin
            rx_overrun_flag_r      <= 1'b0;
            rx_overrun_flag_seen_r <= 1'b0;
        end else if (rd_go && s_axi_araddr_in == `SFPC_ADDR_LSR && rx_overrun_flag_r) begin
            rx_overrun_flag_seen_r <= 1'b1;
        end
        fer_r <= c_fer | (fer_r & ~(w_stat & wv[2]));
        per_r <= c_per | (per_r & ~(w_stat & wv[3]));
        brk_r <= c_brk | (brk_r & ~(w_stat & wv[4]));
    end
end

// Rts threshold; count must exceed the chosen level
reg [4:0] rts_lv;
always @* begin
    case (fcr_r[`SFPC_FCR_RTSLV+2:`SFPC_FCR_RTSLV])
        3'h0:    rts_lv = 5'h0f;
        3'h1:    rts_lv = 5'h01;
        3'h2:    rts_lv = 5'h04;
        3'h3:    rts_lv = 5'h06;
        3'h4:    rts_lv = 5'h08;
        3'h5:    rts_lv = 5'h0a;
        3'h6:    rts_lv = 5'h0c;
        default: rts_lv = 5'h0e;
    endcase
end
wire rts_func = modem_ctrl_enable & ({{(5-FIFO_AW){1'b0}}, rcnt_r[FIFO_AW-1:0]} > rts_lv
                | rcnt_r[FIFO_AW]);

// Serial clock made here: 16x in async 01, bit clock in synchronous
wire sck_gen = sync ? (~tbusy_r | sph_r[3]) : (dcnt_r <= {1'b0, div[7:1]});
wire sck_drv = ~ext & (sync | (cks == 2'b01));

// Pin drivers, all registered
always @(posedge ref_clk_in or negedge rst_r) begin
    if (!rst_r) begin
        txd_r    <= 1'b1;
        sck_r    <= 1'b0;
        sck_oe_r <= 1'b0;
        rts_r    <= 1'b0;
        rts_oe_r <= 1'b0;
        cts_r    <= 1'b1;
        cts_oe_r <= 1'b0;
    end else begin
        txd_r    <= sptr_r[1] ? sptr_r[0] : (txen ? tx_line : 1'b1);
        rts_r    <= sptr_r[7] ? sptr_r[6] : rts_func;
        rts_oe_r <= sptr_r[7] | modem_ctrl_enable;
        cts_r    <= sptr_r[4];
        cts_oe_r <= sptr_r[5];
        sck_r    <= sptr_r[3] ? sptr_r[2] : sck_gen;
        sck_oe_r <= sptr_r[3] | sck_drv;
    end
end

// Read mux; pin-value bits show the synchronised pin levels
reg [31:0] rd_v;
reg        rd_ok;
always @* begin
    rd_v  = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr_in)
        `SFPC_ADDR_MODE: rd_v[23:0] = mode_r;
        `SFPC_ADDR_TXD:  rd_v = 32'h0000_0000;
        `SFPC_ADDR_RXD:  rd_v[7:0] = rmem[rrp_r];
        `SFPC_ADDR_FCR:  rd_v[10:0] = fcr_r;
        `SFPC_ADDR_FDR: begin
            rd_v[`SFPC_FDR_TX +: FIFO_AW+1] = tcnt_r;
            rd_v[FIFO_AW:0] = rcnt_r;
        end
        `SFPC_ADDR_SPTR: rd_v[7:0] = {sptr_r[7], s2_r[3], sptr_r[5], s2_r[2],
                                      sptr_r[3], s2_r[1], sptr_r[1], s2_r[0]};
        `SFPC_ADDR_LSR:  rd_v[0] = rx_overrun_flag_r;
        `SFPC_ADDR_STAT: rd_v[4:0] = {brk_r, per_r, fer_r, rcnt_r == FULL,
                                      rcnt_r != 0};
        default:         rd_ok = 1'b0;
    endcase
end

// Write channels are taken in either order; response follows both
always @(posedge ref_clk_in or negedge rst_r) begin
    if (!rst_r) begin
        awrdy_r  <= 1'b1;
        wrdy_r   <= 1'b1;
        bvalid_r <= 1'b0;
        bresp_r  <= `SFPC_RESP_OK;
        waddr_r  <= 8'h00;
        wdata_r  <= 32'h0000_0000;
        wstrb_r  <= 4'h0;
        arrdy_r  <= 1'b1;
        rvalid_r <= 1'b0;
        rdata_r  <= 32'h0000_0000;
        rresp_r  <= `SFPC_RESP_OK;
    end else begin
        if (s_axi_awvalid_in && awrdy_r) begin
            awrdy_r <= 1'b0;
            waddr_r <= s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && wrdy_r) begin
            wrdy_r  <= 1'b0;
            wdata_r <= s_axi_wdata_in;
            wstrb_r <= s_axi_wstrb_in;
        end
        if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= w_ok ? `SFPC_RESP_OK : `SFPC_RESP_ERR;
        end
        if (bvalid_r && s_axi_bready_in) begin
            bvalid_r <= 1'b0;
            awrdy_r  <= 1'b1;
            wrdy_r   <= 1'b1;
        end
        if (rd_go) begin
            arrdy_r  <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r  <= rd_v;
            rresp_r  <= rd_ok ? `SFPC_RESP_OK : `SFPC_RESP_ERR;
        end
        if (rvalid_r && s_axi_rready_in) begin
            rvalid_r <= 1'b0;
            arrdy_r  <= 1'b1;
        end
    end
end

assign s_axi_awready_out = awrdy_r;
assign s_axi_wready_out  = wrdy_r;
assign s_axi_bvalid_out  = bvalid_r;
assign s_axi_bresp_out   = bresp_r;
assign s_axi_arready_out = arrdy_r;
assign s_axi_rvalid_out  = rvalid_r;
assign s_axi_rdata_out   = rdata_r;
assign s_axi_rresp_out   = rresp_r;
assign txd_out           = txd_r;
assign sck_out           = sck_r;
assign sck_oe_out        = sck_oe_r;
assign rts_out           = rts_r;
assign rts_oe_out        = rts_oe_r;
assign cts_out           = cts_r;
assign cts_oe_out        = cts_oe_r;

endmodule

/* verif/sfpc_partner.sv */
`timescale 1ns/1ps
module sfpc_partner (
    input  wire logic sck_drv_in,
    input  wire logic sck_oe_in,
    input  wire logic rts_drv_in,
    input  wire logic rts_oe_in,
    input  wire logic cts_drv_in,
    input  wire logic cts_oe_in,
    output wire logic rxd_out,
    output wire logic sck_out,
    output wire logic rts_out,
    output wire logic cts_out
);
    logic rxd_r = 1'b1;
    logic sck_r = 1'b0;
    // Line levels; rts has a pull-up, cts is held high (stop) by this side
    assign rxd_out = rxd_r;
    assign sck_out = sck_oe_in ? sck_drv_in : sck_r;
    assign rts_out = rts_oe_in ? rts_drv_in : 1'b1;
    assign cts_out = cts_oe_in ? cts_drv_in : 1'b1;
    // One frame, LSB first; the link clock only runs inside frames
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        begin
            f = {1'b1, b, 1'b0};
            for (int i = 0; i < 10; i++) begin
                rxd_r = f[i];
                repeat (16) begin
                    #100 sck_r = 1'b1;
                    #100 sck_r = 1'b0;
                end
            end
        end
    endtask
endmodule

/* verif/sfpc_properties.sv */
`timescale 1ns/1ps
`include "sfpc_map.vh"
module sfpc_properties (
    input wire logic        ref_clk_in,
    input wire logic        reset_n_in,
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic [1:0]  s_axi_bresp_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic [7:0]  s_axi_araddr_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0]  s_axi_rresp_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in
);
    logic [7:0] ra_r;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    // Keep the read address so its answer can be judged
    always @(posedge ref_clk_in) begin
        if (s_axi_arvalid_in && s_axi_arready_out)
            ra_r <= s_axi_araddr_in;
    end
    // Bus timing as handed over
    a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out |=> !s_axi_awready_out && !s_axi_wready_out ##1 s_axi_bvalid_out)
        else $error("write answer wrong");
    a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out
        |=> s_axi_rvalid_out && !s_axi_arready_out) else $error("read answer late");
    a_bresp_held: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
    a_rdata_held: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer dropped");
    a_read_error: assert property (s_axi_rvalid_out
        |-> (ra_r > `SFPC_ADDR_STAT || ra_r[1:0] != 2'b00) ==
        (s_axi_rresp_out == `SFPC_RESP_ERR)) else $error("read response code wrong");
    // Register contents within their documented fields
    a_fill_fields: assert property (
        s_axi_rvalid_out && ra_r == `SFPC_ADDR_FDR |-> s_axi_rdata_out[31:13] == 19'h0
        && s_axi_rdata_out[7:5] == 3'h0 && s_axi_rdata_out[12:8] <= 5'h10
        && s_axi_rdata_out[4:0] <= 5'h10) else $error("fill count out of range");
    a_port_reserved: assert property (
        s_axi_rvalid_out && ra_r == `SFPC_ADDR_SPTR |-> s_axi_rdata_out[31:8] == 24'h0)
        else $error("pin port upper bits set");
    a_overrun_only: assert property (
        s_axi_rvalid_out && ra_r == `SFPC_ADDR_LSR |-> s_axi_rdata_out[31:1] == 31'h0)
        else $error("line status upper bits set");
endmodule
bind sfpc_top sfpc_properties sfpc_properties_inst (.*);

/* verif/serial_fifo_port_control_tb.sv */
`timescale 1ns/1ps
`include "sfpc_map.vh"
module serial_fifo_port_control_tb;
    logic        ref_clk_in = 1'b0, reset_n_in = 1'b0;
    logic [7:0]  s_axi_awaddr_in = 8'h0, s_axi_araddr_in = 8'h0, v;
    logic [31:0] s_axi_wdata_in = 32'h0, rdat;
    logic [3:0]  s_axi_wstrb_in = 4'hf;
    logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic        s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic [1:0]  rs;
    wire         s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    wire         s_axi_rvalid_out, rxd_in, txd_out, sck_in, sck_out, sck_oe_out;
    wire         rts_in, rts_out, rts_oe_out, cts_in, cts_out, cts_oe_out;
    wire [1:0]   s_axi_bresp_out, s_axi_rresp_out;
    wire [31:0]  s_axi_rdata_out;
    int          n_fail = 0, checked = 0, txn = 0, lv;
    int          rxq[$];
    int          trig[8] = '{15, 1, 4, 6, 8, 10, 12, 14};

    sfpc_top sfpc_top_inst (.*);
    sfpc_partner sfpc_partner_inst (.sck_drv_in(sck_out), .sck_oe_in(sck_oe_out),
        .rts_drv_in(rts_out), .rts_oe_in(rts_oe_out), .cts_drv_in(cts_out),
        .cts_oe_in(cts_oe_out), .rxd_out(rxd_in), .sck_out(sck_in), .rts_out(rts_in),
        .cts_out(cts_in));

    // System clock
    always #12.5 ref_clk_in = ~ref_clk_in;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            checked++;
            if (got !== exp) begin
                n_fail++;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        begin
            s_axi_awaddr_in <= a;
            s_axi_wdata_in <= d;
            s_axi_awvalid_in <= 1'b1;
            s_axi_wvalid_in <= 1'b1;
            s_axi_bready_in <= 1'b1;
            do begin
                @(posedge ref_clk_in);
                if (s_axi_awvalid_in && s_axi_awready_out)
                    s_axi_awvalid_in <= 1'b0;
                if (s_axi_wvalid_in && s_axi_wready_out)
                    s_axi_wvalid_in <= 1'b0;
            end while (!s_axi_bvalid_out);
            rs = s_axi_bresp_out;
            s_axi_bready_in <= 1'b0;
            @(posedge ref_clk_in);
        end
    endtask

    task automatic rd(input logic [7:0] a);
        begin
            s_axi_araddr_in <= a;
            s_axi_arvalid_in <= 1'b1;
            s_axi_rready_in <= 1'b1;
            do begin
                @(posedge ref_clk_in);
                if (s_axi_arvalid_in && s_axi_arready_out)
                    s_axi_arvalid_in <= 1'b0;
            end while (!s_axi_rvalid_out);
            rdat = s_axi_rdata_out;
            rs = s_axi_rresp_out;
            s_axi_rready_in <= 1'b0;
            @(posedge ref_clk_in);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        begin
            rd(a);
            chk(rs, `SFPC_RESP_OK);
            chk(rdat, e);
        end
    endtask

    // Model view of the fill counters
    function automatic logic [31:0] fdr();
        return {19'h0, 5'(txn), 3'h0, 5'(rxq.size())};
    endfunction

    task automatic end_of_test;
        begin
            $display("checks %0d mismatches %0d", checked, n_fail);
            if (n_fail == 0 && checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    initial begin
        void'($urandom(35));
        repeat (6) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        rdc(`SFPC_ADDR_FCR, 32'h0);
        rdc(`SFPC_ADDR_FDR, 32'h0);
        rdc(`SFPC_ADDR_SPTR, 32'h51);
        rdc(`SFPC_ADDR_LSR, 32'h0);
        rd(8'h20);
        chk(rs, `SFPC_RESP_ERR);
        wr(8'h24, 32'h0);
        chk(rs, `SFPC_RESP_ERR);
        $display("test reset done");
        // Random port settings; wait covers the pin and read-back lag
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            wr(`SFPC_ADDR_SPTR, {24'h0, v});
            repeat (4) @(posedge ref_clk_in);
            chk(rts_out, v[7] & v[6]);
            chk({rts_oe_out, cts_oe_out, sck_oe_out}, {v[7], v[5], v[3]});
            chk(txd_out, v[1] ? v[0] : 1'b1);
            rdc(`SFPC_ADDR_SPTR, {24'h0, v[7], v[7] ? v[6] : 1'b1, v[5], v[5] ? v[4] : 1'b1,
                v[3], v[3] & v[2], v[1], 1'b1});
        end
        wr(`SFPC_ADDR_SPTR, 32'h50);
        $display("test pins done");
        // Receive from the link clock pin into a full FIFO, level walks all triggers
        wr(`SFPC_ADDR_MODE, 32'h140);
        for (int i = 0; i < 17; i++) begin
            lv = i % 8;
            wr(`SFPC_ADDR_FCR, {21'h0, 3'(lv), 8'h08});
            v = 8'($urandom);
            sfpc_partner_inst.send(v);
            if (rxq.size() < 16)
                rxq.push_back(v);
            rdc(`SFPC_ADDR_FDR, fdr());
            chk(rts_out, rxq.size() > trig[lv]);
        end
        wr(`SFPC_ADDR_LSR, 32'h0);
        rdc(`SFPC_ADDR_LSR, 32'h1);
        rd(`SFPC_ADDR_RXD);
        chk(rdat[7:0], rxq.pop_front());
        wr(`SFPC_ADDR_LSR, 32'h1);
        wr(`SFPC_ADDR_MODE, 32'h40);
        rdc(`SFPC_ADDR_LSR, 32'h1);
        wr(`SFPC_ADDR_LSR, 32'h0);
        rdc(`SFPC_ADDR_LSR, 32'h0);
        wr(`SFPC_ADDR_FCR, 32'h2);
        rxq.delete();
        rdc(`SFPC_ADDR_FDR, fdr());
        $display("test receive done");
        // Transmitter off: pushes pile up, the one past full is dropped
        for (int i = 0; i < 17; i++) begin
            wr(`SFPC_ADDR_TXD, $urandom);
            if (txn < 16)
                txn++;
        end
        rdc(`SFPC_ADDR_FDR, fdr());
        wr(`SFPC_ADDR_FCR, 32'h4);
        txn = 0;
        rdc(`SFPC_ADDR_FDR, fdr());
        $display("test transmit done");
        // Wrap test at the fastest internal rate: one parity frame comes back
        wr(`SFPC_ADDR_FCR, 32'h1);
        wr(`SFPC_ADDR_MODE, 32'h184);
        chk(sck_oe_out, 1'b0);
        v = 8'($urandom);
        wr(`SFPC_ADDR_TXD, {24'h0, v});
        rxq.push_back(v);
        repeat (250) @(posedge ref_clk_in);
        rdc(`SFPC_ADDR_FDR, fdr());
        rdc(`SFPC_ADDR_STAT, 32'h1);
        rd(`SFPC_ADDR_RXD);
        chk(rdat[7:0], rxq.pop_front());
        // Synchronous mode, modem control off: clock pin driven only when internal
        wr(`SFPC_ADDR_MODE, 32'h1);
        chk({sck_oe_out, sck_out}, 2'b11);
        wr(`SFPC_ADDR_MODE, 32'h41);
        chk(sck_oe_out, 1'b0);
        $display("test loop done");
        end_of_test();
    end

    // Watchdog well beyond the expected run of about 0.6 ms
    initial begin
        #1500000;
        n_fail++;
        end_of_test();
    end
endmodule
